// ### core/sxsp_unit.sv
// Byte-wide serial port unit: slave on the link clock, master on the bus clock
`timescale 1ns/1ps
`include "sxsp_regs.svh"

module sxsp_unit (
  // Bus clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Control bits, to be changed only while disabled
  input wire logic unit_enable_bit_i,
  input wire logic master_select_bit_i,
  input wire logic clock_polarity_bit_i,
  input wire logic clock_phase_bit_i,
  input wire logic [1:0] rate_select_bits_i,
  // Data register access strobes
  input wire logic data_wr_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic data_rd_i,
  input wire logic status_rd_i,
  // Data register and flags
  output logic [7:0] data_rdata_o,
  output logic receive_full_flag_o,
  output logic transmit_empty_flag_o,
  output logic master_busy_o,
  // Serial link
  sxsp_if.dev link
);

  // --------------------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------------------
  // Control bits are quasi-static: software keeps them still while enabled
  wire slave_act = unit_enable_bit_i & ~master_select_bit_i;
  wire master_act = unit_enable_bit_i & master_select_bit_i;
  // Sampling edge is the rising edge of this clock for all four formats
  wire link_clk = link.sclk ^ clock_polarity_bit_i ^ clock_phase_bit_i;
  // Deselect clears the bit counters, so a half byte never carries over
  wire link_rst_n = rst_n_i & slave_act & ~link.ss_n;

  // --------------------------------------------------------------------------
  // Link domain: receive shifter on the sampling edge
  // --------------------------------------------------------------------------
  logic [2:0] smp_cnt_reg;
  logic [6:0] rx_sh_reg;
  logic [7:0] rx_word_reg;
  logic rx_tgl_reg;
  logic [2:0] sh_cnt_reg;
  logic [7:0] tx_word_reg;
  wire rx_last = (smp_cnt_reg == `SXSP_LAST_BIT);

  // Bit counter and shifter, cleared by deselect
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      smp_cnt_reg <= 3'h0;
      rx_sh_reg <= 7'h00;
    end else begin
      smp_cnt_reg <= smp_cnt_reg + 3'h1;
      rx_sh_reg <= {rx_sh_reg[5:0], link.mosi};
    end
  end

  // Completed byte and its toggle survive deselect so no event is lost
  always_ff @(posedge link_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_word_reg <= 8'h00;
      rx_tgl_reg <= 1'b0;
    end else if (link_rst_n && rx_last) begin
      rx_word_reg <= {rx_sh_reg, link.mosi};
      rx_tgl_reg <= ~rx_tgl_reg;
    end
  end

  // Shift-edge counter; phase one counts its first edge as the start
  always_ff @(negedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sh_cnt_reg <= 3'h0;
    end else begin
      sh_cnt_reg <= sh_cnt_reg + 3'h1;
    end
  end

  // Bit index: phase zero shows MSB from select, phase one from first edge
  wire [2:0] tx_idx = sh_cnt_reg - {2'b00, clock_phase_bit_i};
  wire [2:0] tx_pos = `SXSP_LAST_BIT - tx_idx;

  // Slave output pins; the wire is released whenever deselected
  assign link.dev_miso_o = tx_word_reg[tx_pos];
  assign link.dev_miso_oe = slave_act & ~link.ss_n;

  // --------------------------------------------------------------------------
  // Bus domain: synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] rx_tgl_sync_reg;
  logic [1:0] ss_sync_reg;
  logic [1:0] miso_sync_reg;

  // Two flops per crossing, a third for toggle edge detection
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_tgl_sync_reg <= 3'h0;
      ss_sync_reg <= 2'b11;
      miso_sync_reg <= 2'b11;
    end else begin
      rx_tgl_sync_reg <= {rx_tgl_sync_reg[1:0], rx_tgl_reg};
      ss_sync_reg <= {ss_sync_reg[0], link.ss_n};
      miso_sync_reg <= {miso_sync_reg[0], link.miso};
    end
  end

  wire slave_done = slave_act & (rx_tgl_sync_reg[2] ^ rx_tgl_sync_reg[1]);
  wire ss_idle = ss_sync_reg[1];
  wire miso_s = miso_sync_reg[1];

  // --------------------------------------------------------------------------
  // Master: free-running prescaler and sequencer
  // --------------------------------------------------------------------------
  sxsp_pkg::sxsp_mst_state_t mst_state_reg;
  sxsp_pkg::sxsp_mst_state_t mst_state_next;
  logic [6:0] presc_reg;
  logic [3:0] half_reg;
  logic [7:0] mst_sh_reg;
  logic sclk_lvl_reg;
  logic sclk_pin_reg;
  logic [6:0] half_len;

  // Rate select to half bit length
  always_comb begin
    unique case (rate_select_bits_i)
      `SXSP_RATE_DIV2: half_len = `SXSP_HALF_DIV2;
      `SXSP_RATE_DIV8: half_len = `SXSP_HALF_DIV8;
      `SXSP_RATE_DIV32: half_len = `SXSP_HALF_DIV32;
      `SXSP_RATE_RATE_DIVIDE_BY_128: half_len = `SXSP_HALF_RATE_DIVIDE_BY_128;
    endcase
  end

  wire tick = master_act & (presc_reg == half_len - 7'h01);
  wire mst_run = (mst_state_reg == sxsp_pkg::SXSP_M_RUN);
  wire mst_done = mst_run & tick & (half_reg == `SXSP_LAST_HALF);
  wire mst_free = (mst_state_reg == sxsp_pkg::SXSP_M_IDLE) | mst_done;
  // Phase zero idles the first half; phase one opens with an active edge
  wire sclk_run = clock_polarity_bit_i ^ (clock_phase_bit_i ^ half_reg[0]);

  // Prescaler stopped to save power unless enabled as master
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_reg <= 7'h00;
    end else if (!master_act || tick) begin
      presc_reg <= 7'h00;
    end else begin
      presc_reg <= presc_reg + 7'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Transmit holding register
  // --------------------------------------------------------------------------
  logic [7:0] tx_buf_reg;
  logic tx_empty_reg;
  wire tx_have = ~tx_empty_reg | data_wr_i;
  wire [7:0] tx_data = data_wr_i ? data_wdata_i : tx_buf_reg;
  // Slave loads only between transfers; a late write waits its turn
  wire slave_load = slave_act & tx_have & (ss_idle | slave_done);
  wire master_load = master_act & tx_have & mst_free;
  wire tx_load = slave_load | master_load;

  // Load empties the buffer; that set wins over a write's clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_buf_reg <= 8'h00;
      tx_empty_reg <= `SXSP_TX_EMPTY_RST;
    end else begin
      if (data_wr_i) begin
        tx_buf_reg <= data_wdata_i;
      end
      tx_empty_reg <= tx_load | (tx_empty_reg & ~data_wr_i);
    end
  end

  // Slave shift source; otherwise the old byte is sent again
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_word_reg <= 8'h00;
    end else if (slave_load) begin
      tx_word_reg <= tx_data;
    end
  end

  // Master next state; start waits for the next prescaler tick
  always_comb begin
    mst_state_next = mst_state_reg;
    unique case (mst_state_reg)
      sxsp_pkg::SXSP_M_IDLE: if (master_load) mst_state_next = sxsp_pkg::SXSP_M_WAIT;
      sxsp_pkg::SXSP_M_WAIT: if (tick) mst_state_next = sxsp_pkg::SXSP_M_RUN;
      sxsp_pkg::SXSP_M_RUN: begin
        if (mst_done) begin
          mst_state_next = master_load ? sxsp_pkg::SXSP_M_WAIT : sxsp_pkg::SXSP_M_IDLE;
        end
      end
      default: mst_state_next = sxsp_pkg::SXSP_M_IDLE;
    endcase
    if (!master_act) begin
      mst_state_next = sxsp_pkg::SXSP_M_IDLE;
    end
  end

  // Master shifter: sample at end of each odd half, shift out next bit
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mst_state_reg <= sxsp_pkg::SXSP_M_IDLE;
      half_reg <= 4'h0;
      mst_sh_reg <= 8'h00;
      sclk_lvl_reg <= 1'b0;
    end else begin
      mst_state_reg <= mst_state_next;
      if (master_load) begin
        mst_sh_reg <= tx_data;
      end else if (mst_run && tick && half_reg[0]) begin
        mst_sh_reg <= {mst_sh_reg[6:0], miso_s};
      end
      if (mst_state_next != sxsp_pkg::SXSP_M_RUN) begin
        half_reg <= 4'h0;
      end else if (mst_run && tick) begin
        half_reg <= half_reg + 4'h1;
      end
      sclk_lvl_reg <= (mst_state_next == sxsp_pkg::SXSP_M_RUN && !(mst_run && tick))
                      ? sclk_run : (mst_run && tick && !mst_done)
                      ? ~sclk_run : clock_polarity_bit_i;
    end
  end

  // Clock pin moves on the falling bus edge, mid bus cycle
  always_ff @(negedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_pin_reg <= 1'b0;
    end else begin
      sclk_pin_reg <= sclk_lvl_reg;
    end
  end

  // Master drives clock and data only when enabled as master
  assign link.dev_sclk_o = sclk_pin_reg;
  assign link.dev_sclk_oe = master_act;
  assign link.dev_mosi_o = mst_sh_reg[7];
  assign link.dev_mosi_oe = master_act;

  // --------------------------------------------------------------------------
  // Receive data register and receive-full flag
  // --------------------------------------------------------------------------
  logic [7:0] rx_data_reg;
  logic rx_full_reg;
  logic rx_armed_reg;
  wire rx_set = slave_done | mst_done;
  wire [7:0] rx_new = slave_done ? rx_word_reg : {mst_sh_reg[6:0], miso_s};
  wire rx_clr = data_rd_i & rx_armed_reg;

  // Unread byte is kept; a new byte is dropped while the flag is set, unless a clearing read comes in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_data_reg <= 8'h00;
      rx_full_reg <= `SXSP_RX_FULL_RST;
      rx_armed_reg <= 1'b0;
    end else begin
      if (rx_set && (!rx_full_reg || rx_clr)) begin
        rx_data_reg <= rx_new;
      end
      rx_full_reg <= rx_set | (rx_full_reg & ~rx_clr);
      if (status_rd_i && rx_full_reg) begin
        rx_armed_reg <= 1'b1;
      end else if (data_rd_i) begin
        rx_armed_reg <= 1'b0;
      end
    end
  end

  // Register views
  assign data_rdata_o = rx_data_reg;
  assign receive_full_flag_o = rx_full_reg;
  assign transmit_empty_flag_o = tx_empty_reg;
  assign master_busy_o = (mst_state_reg != sxsp_pkg::SXSP_M_IDLE);

endmodule : sxsp_unit

// ### pkg/sxsp_regs.svh
// Constants shared by both ends of the serial link
`ifndef SXSP_REGS_SVH
`define SXSP_REGS_SVH

// ----------------------------------------------------------------------------
// Rate select codes
// ----------------------------------------------------------------------------
`define SXSP_RATE_DIV2 2'b00
`define SXSP_RATE_DIV8 2'b01
`define SXSP_RATE_DIV32 2'b10
`define SXSP_RATE_RATE_DIVIDE_BY_128 2'b11

// ----------------------------------------------------------------------------
// Half bit times in bus cycles (a bit time is twice this)
// ----------------------------------------------------------------------------
`define SXSP_HALF_DIV2 7'h01
`define SXSP_HALF_DIV8 7'h04
`define SXSP_HALF_DIV32 7'h10
`define SXSP_HALF_RATE_DIVIDE_BY_128 7'h40

// ----------------------------------------------------------------------------
// Frame shape
// ----------------------------------------------------------------------------
`define SXSP_LAST_BIT 3'h7
`define SXSP_LAST_HALF 4'hF
`define SXSP_PEER_HALF 3'h4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SXSP_TX_EMPTY_RST 1'b1
`define SXSP_RX_FULL_RST 1'b0

`endif

// ### pkg/sxsp_pkg.sv
// Types shared by both ends of the serial link
package sxsp_pkg;

  // --------------------------------------------------------------------------
  // Master sequencer of the unit
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SXSP_M_IDLE = 2'b00,
    SXSP_M_WAIT = 2'b01,
    SXSP_M_RUN = 2'b10
  } sxsp_mst_state_t;

  // --------------------------------------------------------------------------
  // Sequencer of the external master
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SXSP_P_IDLE = 3'b000,
    SXSP_P_LEAD = 3'b001,
    SXSP_P_RUN = 3'b010,
    SXSP_P_TRAIL = 3'b011,
    SXSP_P_GAP = 3'b100
  } sxsp_peer_state_t;

endpackage : sxsp_pkg

// ### pkg/sxsp_if.sv
// Serial link wires joining the unit and the external controller
`timescale 1ns/1ps

interface sxsp_if;
  // Unit side drivers
  logic dev_sclk_o;
  logic dev_sclk_oe;
  logic dev_mosi_o;
  logic dev_mosi_oe;
  logic dev_miso_o;
  logic dev_miso_oe;
  // External side drivers
  logic peer_sclk_o;
  logic peer_sclk_oe;
  logic peer_mosi_o;
  logic peer_mosi_oe;
  logic peer_miso_o;
  logic peer_miso_oe;
  logic peer_ss_n_o;
  logic peer_ss_n_oe;
  // Resolved wire levels; undriven wires read as idle high
  logic sclk;
  logic mosi;
  logic miso;
  logic ss_n;

  // Wire resolution from the enables
  assign sclk = dev_sclk_oe ? dev_sclk_o : (peer_sclk_oe ? peer_sclk_o : 1'b1);
  assign mosi = dev_mosi_oe ? dev_mosi_o : (peer_mosi_oe ? peer_mosi_o : 1'b1);
  assign miso = dev_miso_oe ? dev_miso_o : (peer_miso_oe ? peer_miso_o : 1'b1);
  assign ss_n = peer_ss_n_oe ? peer_ss_n_o : 1'b1;

  modport dev (
    input sclk, mosi, miso, ss_n,
    output dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe
  );

  modport peer (
    input sclk, mosi, miso, ss_n,
    output peer_sclk_o, peer_sclk_oe, peer_mosi_o, peer_mosi_oe, peer_miso_o, peer_miso_oe,
    output peer_ss_n_o, peer_ss_n_oe
  );
endinterface : sxsp_if

// ### core/sxsp_peer.sv
// External master controller driving the unit's link
`timescale 1ns/1ps
`include "sxsp_regs.svh"

module sxsp_peer (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Format selection, matched to the unit
  input wire logic clock_polarity_bit_i,
  input wire logic clock_phase_bit_i,
  // Transfer request
  input wire logic start_i,
  input wire logic [7:0] tx_data_i,
  // Transfer result
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rx_data_o,
  // Serial link
  sxsp_if.peer link
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  sxsp_pkg::sxsp_peer_state_t state_reg;
  logic [2:0] cnt_reg;
  logic [3:0] half_reg;
  logic [7:0] sh_reg;
  logic sclk_reg;
  logic ss_n_reg;
  logic done_reg;
  logic [7:0] rx_reg;
  logic [1:0] miso_sync_reg;

  // Half bit of four bus cycles keeps the link well under the unit's bus rate
  wire half_end = (cnt_reg == `SXSP_PEER_HALF - 3'h1);
  wire miso_s = miso_sync_reg[1];
  wire [3:0] half_inc = half_reg + 4'h1;
  wire sclk_at = clock_polarity_bit_i ^ clock_phase_bit_i ^ half_inc[0];

  // Two-flop synchroniser on the returning data
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miso_sync_reg <= 2'b11;
    end else begin
      miso_sync_reg <= {miso_sync_reg[0], link.miso};
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer: select, sixteen halves, trailing half, deselect gap
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= sxsp_pkg::SXSP_P_IDLE;
      cnt_reg <= 3'h0;
      half_reg <= 4'h0;
      sh_reg <= 8'h00;
      sclk_reg <= 1'b0;
      ss_n_reg <= 1'b1;
      done_reg <= 1'b0;
      rx_reg <= 8'h00;
    end else begin
      done_reg <= 1'b0;
      cnt_reg <= (state_reg == sxsp_pkg::SXSP_P_IDLE || half_end) ? 3'h0 : cnt_reg + 3'h1;
      unique case (state_reg)
        sxsp_pkg::SXSP_P_IDLE: begin
          sclk_reg <= clock_polarity_bit_i;
          if (start_i) begin
            sh_reg <= tx_data_i;
            ss_n_reg <= 1'b0;
            state_reg <= sxsp_pkg::SXSP_P_LEAD;
          end
        end
        sxsp_pkg::SXSP_P_LEAD: begin
          if (half_end) begin
            half_reg <= 4'h0;
            // Phase one opens with an edge, phase zero holds idle
            sclk_reg <= clock_polarity_bit_i ^ clock_phase_bit_i;
            state_reg <= sxsp_pkg::SXSP_P_RUN;
          end
        end
        sxsp_pkg::SXSP_P_RUN: begin
          if (half_end) begin
            if (half_reg[0]) begin
              sh_reg <= {sh_reg[6:0], miso_s};
            end
            if (half_reg == `SXSP_LAST_HALF) begin
              sclk_reg <= clock_polarity_bit_i;
              state_reg <= sxsp_pkg::SXSP_P_TRAIL;
            end else begin
              half_reg <= half_inc;
              sclk_reg <= sclk_at;
            end
          end
        end
        sxsp_pkg::SXSP_P_TRAIL: begin
          if (half_end) begin
            // Select released between bytes, needed for phase zero
            ss_n_reg <= 1'b1;
            rx_reg <= sh_reg;
            done_reg <= 1'b1;
            state_reg <= sxsp_pkg::SXSP_P_GAP;
          end
        end
        sxsp_pkg::SXSP_P_GAP: if (half_end) state_reg <= sxsp_pkg::SXSP_P_IDLE;
        default: state_reg <= sxsp_pkg::SXSP_P_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Outputs; the data line returning from the slave is never driven here
  // --------------------------------------------------------------------------
  assign link.peer_sclk_o = sclk_reg;
  assign link.peer_sclk_oe = 1'b1;
  assign link.peer_mosi_o = sh_reg[7];
  assign link.peer_mosi_oe = 1'b1;
  assign link.peer_miso_o = 1'b0;
  assign link.peer_miso_oe = 1'b0;
  assign link.peer_ss_n_o = ss_n_reg;
  assign link.peer_ss_n_oe = 1'b1;
  assign busy_o = (state_reg != sxsp_pkg::SXSP_P_IDLE);
  assign done_o = done_reg;
  assign rx_data_o = rx_reg;

endmodule : sxsp_peer

// ### sim/sxsp_link_chk.sv
// Concurrent checks on the serial link between the unit and the external master
`timescale 1ns/1ps

module sxsp_link_chk (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Link wires and unit enables
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic dev_sclk_oe,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_oe
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ---------------------------------------------------------------------------
  // Clock edge count per frame
  // ---------------------------------------------------------------------------
  logic sclk_reg;
  logic [4:0] edge_cnt_reg;
  logic [4:0] edge_cnt_next;
  // Deselect clears the count, so idle polarity moves never add up
  assign edge_cnt_next = ss_n ? 5'h00 : edge_cnt_reg + {4'h0, sclk != sclk_reg};
  // Registers for the edge counter
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_reg <= 1'b0;
      edge_cnt_reg <= 5'h00;
    end else begin
      sclk_reg <= sclk;
      edge_cnt_reg <= edge_cnt_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_miso_only_selected: assert property (dev_miso_oe |-> !ss_n)
    else $error("data return driven while deselected");
  a_miso_on_select: assert property ($fell(ss_n) && !dev_sclk_oe |-> dev_miso_oe)
    else $error("data return not driven on select");
  a_slave_clock_input: assert property (dev_miso_oe |-> !dev_sclk_oe && !dev_mosi_oe)
    else $error("selected unit drives clock or master data");
  a_master_unselected: assert property (dev_sclk_oe |-> ss_n)
    else $error("select input low while unit is master");
  a_select_holds: assert property ($fell(ss_n) |-> !ss_n [*8])
    else $error("select released early");
  a_frame_length: assert property ($fell(ss_n) |-> ##[68:76] $rose(ss_n))
    else $error("select low for a wrong span");
  a_select_gap: assert property ($rose(ss_n) |-> ss_n [*4])
    else $error("select gap too short");
  a_frame_edges: assert property ($rose(ss_n) |-> edge_cnt_reg == 5'h10)
    else $error("frame clock edge count wrong");

  // Main scenarios reached
  c_frame: cover property ($fell(ss_n));
  c_master: cover property ($rose(dev_sclk_oe));
  c_full_frame: cover property ($rose(ss_n) && edge_cnt_reg == 5'h10);
endmodule : sxsp_link_chk

// ### sim/spi_slave_and_transfer_formats_tb.sv
// Self-checking bench joining the unit and the external master
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module spi_slave_and_transfer_formats_tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic en = 1'b0, mst = 1'b0, clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0;
  logic [1:0] rate = 2'h0;
  logic wr = 1'b0, rd = 1'b0, srd = 1'b0, start = 1'b0;
  logic [7:0] wdata = 8'h00, ptx = 8'h00;
  logic [7:0] rdata, prx;
  logic [7:0] mtx = 8'h00;
  logic rxf, txe, mbusy, pbusy, pdone;
  logic [7:0] stx [4] = '{8'hC3, 8'h5A, 8'h96, 8'h81};
  int failures = 0, cmp_count = 0, n, lim;

  // ---------------------------------------------------------------------------
  // Link and both ends
  // ---------------------------------------------------------------------------
  sxsp_if link ();
  sxsp_unit i_sxsp_unit (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .unit_enable_bit_i(en),
    .master_select_bit_i(mst), .clock_polarity_bit_i(clock_polarity_bit), .clock_phase_bit_i(clock_phase_bit),
    .rate_select_bits_i(rate), .data_wr_i(wr), .data_wdata_i(wdata), .data_rd_i(rd),
    .status_rd_i(srd), .data_rdata_o(rdata), .receive_full_flag_o(rxf),
    .transmit_empty_flag_o(txe), .master_busy_o(mbusy), .link(link.dev));
  sxsp_peer i_sxsp_peer (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .clock_polarity_bit_i(clock_polarity_bit), .clock_phase_bit_i(clock_phase_bit), .start_i(start), .tx_data_i(ptx),
    .busy_o(pbusy), .done_o(pdone), .rx_data_o(prx), .link(link.peer));
  sxsp_link_chk i_sxsp_link_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sclk(link.sclk),
    .ss_n(link.ss_n), .dev_sclk_oe(link.dev_sclk_oe), .dev_mosi_oe(link.dev_mosi_oe),
    .dev_miso_oe(link.dev_miso_oe));

  // Bus clock, 40 ns
  initial forever #20 ref_clk_i = ~ref_clk_i;

  // Master data taken on the falling clock edge; only idle-low phase-one is used
  always @(negedge link.sclk) begin
    if (link.dev_sclk_oe) mtx <= {mtx[6:0], link.mosi};
  end

  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  // Inputs move 1 ns after the rising edge
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask : tick

  // Polls done, receive-full or peer idle with a bound
  task automatic wait_hi(input int sel, input int lim_c);
    for (n = 0; n < lim_c; n++) begin
      if ((sel == 0 ? pdone : sel == 1 ? rxf : !pbusy) === 1'b1) break;
      tick(1);
    end
    if (n == lim_c) failures++;
  endtask : wait_hi

  // Format bits only move while the unit is disabled
  task automatic cfg(input logic m, input logic p, input logic h, input logic [1:0] r);
    en = 1'b0;
    tick(2);
    mst = m;
    clock_polarity_bit = p;
    clock_phase_bit = h;
    rate = r;
    tick(2);
    en = 1'b1;
    tick(2);
  endtask : cfg

  task automatic unit_write(input logic [7:0] b);
    wdata = b;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask : unit_write

  // A data read alone must not clear the flag
  task automatic clear_rx();
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    `CHK("rxf_kept", 1'b1, rxf)
    srd = 1'b1;
    tick(1);
    srd = 1'b0;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    `CHK("rxf_clr", 1'b0, rxf)
  endtask : clear_rx

  task automatic frame(input logic [7:0] b);
    wait_hi(2, 100);
    ptx = b;
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask : frame

  task automatic finish_frame(input logic [7:0] sent, input logic [7:0] exp);
    wait_hi(0, 200);
    `CHK("peer_rx", exp, prx)
    wait_hi(1, 200);
    `CHK("unit_rx", sent, rdata)
    clear_rx();
  endtask : finish_frame

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    tick(8);
    rst_n_i = 1'b1;
    tick(1);
    `CHK("rxf_rst", 1'b0, rxf)
    `CHK("txe_rst", 1'b1, txe)
    `CHK("busy_rst", 1'b0, mbusy)
    // Slave in each of the four formats, both directions at once
    for (int m = 0; m < 4; m++) begin
      cfg(1'b0, m[1], m[0], 2'h0);
      unit_write(stx[m]);
      // Idle slave moves the byte at once, so the flag never drops
      `CHK("txe_wr", 1'b1, txe)
      tick(4);
      frame(~stx[m]);
      finish_frame(~stx[m], stx[m]);
    end
    // Resend without a write, then a write landing mid-frame waits
    for (int h = 0; h < 2; h++) begin
      cfg(1'b0, 1'b0, h[0], 2'h0);
      unit_write(8'h42);
      tick(4);
      frame(8'h3C);
      finish_frame(8'h3C, 8'h42);
      frame(8'h69);
      tick(12);
      unit_write(8'hE7);
      `CHK("txe_held", 1'b0, txe)
      finish_frame(8'h69, 8'h42);
      frame(8'h18);
      finish_frame(8'h18, 8'hE7);
    end
    // Master: start delay per rate; released return line reads ones
    for (int r = 1; r < 4; r++) begin
      cfg(1'b1, 1'b0, 1'b1, r[1:0]);
      lim = (2 << (2 * r)) + 1;
      unit_write(8'hA5);
      `CHK("mst_busy", 1'b1, mbusy)
      for (n = 0; n < 300 && link.sclk === 1'b0; n++) tick(1);
      `CHK("start_delay", 1'b1, n <= lim)
      wait_hi(1, 3000);
      `CHK("master_rx", 8'hFF, rdata)
      `CHK("master_tx", 8'hA5, mtx)
      clear_rx();
    end
    test_done();
  end

  // Whole run is a few thousand cycles; cut off at 20000
  initial begin
    #800000;
    failures++;
    test_done();
  end
endmodule : spi_slave_and_transfer_formats_tb
